// *** rtl/cap_params.svh ***
// Purpose: Constants for the center-aligned PWM channel
// Assumes: 20 MHz core clock
// Notes:   Values used by both design files
`ifndef CAP_PARAMS_SVH
`define CAP_PARAMS_SVH
`define CAP_CNT_W       16
`define CAP_PS_W        3
`define CAP_PS_DIV2     3'h1
`define CAP_CNT_RST     16'h0000
`define CAP_MOD_RST     16'h0000
`define CAP_CHV_RST     16'h8000
`define CAP_SIGN_BIT    15
`endif

// *** rtl/cap_pkg.sv ***
// Purpose: Types for the center-aligned PWM channel
// Assumes: Nothing
// Notes:   Types only
package cap_pkg;
  typedef enum logic {CAP_DOWN, CAP_UP} cap_dir_e;
endpackage

// *** rtl/cap_tick_if.sv ***
// Purpose: Carries the counter tick between the channel modules
// Assumes: One clock domain
// Notes:   Divider drives, channel consumes
`timescale 1ns/10ps
`default_nettype none
interface cap_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface
`default_nettype wire

// *** rtl/cap_prescaler.sv ***
// Purpose: Counter-clock enable from the prescale select
// Assumes: Select is stable or changes rarely
// Notes:   Divider restarts from zero on a select change
`timescale 1ns/10ps
`default_nettype none
`include "cap_params.svh"
module cap_prescaler (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Select
  input  wire logic [2:0]        prescaleSelect,
  // Tick out
  cap_tick_if.src                tickBus
);
  logic       phase_ff;
  logic       nxt_phase;
  logic [2:0] selSeen_ff;
  logic       tick_ff;
  logic       nxt_tick;

  always_comb begin
    nxt_phase = ~phase_ff;
    nxt_tick  = 1'b1;
    if (prescaleSelect != selSeen_ff) begin
      // Restart so the first counter edge after a change is predictable
      nxt_phase = 1'b0;
      nxt_tick  = 1'b0;
    end else if (prescaleSelect == `CAP_PS_DIV2) begin
      nxt_tick = phase_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_ff   <= 1'b0;
      selSeen_ff <= 3'h0;
      tick_ff    <= 1'b0;
    end else begin
      phase_ff   <= nxt_phase;
      selSeen_ff <= prescaleSelect;
      tick_ff    <= nxt_tick;
    end
  end

  assign tickBus.tick = tick_ff;

  div2_rate_a: assert property (@(posedge core_clk) disable iff (srst)
    (tick_ff && prescaleSelect == `CAP_PS_DIV2 && $stable(prescaleSelect)
     && selSeen_ff == prescaleSelect) |=> !tick_ff)
    else $error("Divide-by-two tick on consecutive cycles");
endmodule
`default_nettype wire

// *** rtl/cap_pwm_channel.sv ***
// Purpose: Center-aligned PWM channel with period-boundary duty update
// Assumes: Software writes both bytes before the period boundary
// Notes:   Output is active high
`timescale 1ns/10ps
`default_nettype none
`include "cap_params.svh"
module cap_pwm_channel (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  // Settings
  input  wire logic [15:0]            channelValue,
  input  wire logic [15:0]            moduloValue,
  input  wire logic [2:0]             prescaleSelect,
  // Output and status
  output logic                        pwmOut,
  output logic [15:0]                 counterValue,
  output logic                        countingUp,
  output logic                        periodStart
);
  cap_tick_if tickBus ();

  cap_prescaler uPre (
    .core_clk       (core_clk),
    .srst           (srst),
    .prescaleSelect (prescaleSelect),
    .tickBus        (tickBus)
  );

  logic [15:0]         cnt_ff;
  logic [15:0]         nxt_cnt;
  cap_pkg::cap_dir_e   dir_ff;
  cap_pkg::cap_dir_e   nxt_dir;
  logic [15:0]         activeVal_ff;
  logic [15:0]         nxt_activeVal;
  logic                out_ff;
  logic                nxt_out;
  logic                start_ff;
  logic                nxt_start;
  logic                boundary;
  // Direction flag kept in its own flop so the status pin has no decode behind it
  logic                upOut_ff;
  logic                nxt_upOut;

  // Period boundary is the turn at modulo, where down counting starts
  assign boundary = tickBus.tick && (dir_ff == cap_pkg::CAP_UP) && (cnt_ff >= moduloValue);

  always_comb begin
    nxt_cnt       = cnt_ff;
    nxt_dir       = dir_ff;
    nxt_activeVal = activeVal_ff;
    nxt_start     = 1'b0;
    if (tickBus.tick) begin
      unique case (dir_ff)
        cap_pkg::CAP_DOWN: begin
          if (cnt_ff == 16'h0000) begin
            nxt_dir = cap_pkg::CAP_UP;
            nxt_cnt = (moduloValue == 16'h0000) ? 16'h0000 : 16'h0001;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
        cap_pkg::CAP_UP: begin
          if (boundary) begin
            nxt_dir       = cap_pkg::CAP_DOWN;
            nxt_cnt       = (moduloValue == 16'h0000) ? 16'h0000 : moduloValue - 16'h0001;
            // Duty latched only here, so mid-period writes never glitch the pulse
            nxt_activeVal = channelValue;
            nxt_start     = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
      endcase
    end
  end

  always_comb begin
    nxt_upOut = (nxt_dir == cap_pkg::CAP_UP);
    if (nxt_activeVal[`CAP_SIGN_BIT]) begin
      nxt_out = 1'b0;
    end else if (nxt_activeVal >= moduloValue) begin
      nxt_out = 1'b1;
    end else begin
      // Strict compare; modulo minus one still yields proportional duty
      nxt_out = (nxt_cnt < nxt_activeVal);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff       <= `CAP_CNT_RST;
      dir_ff       <= cap_pkg::CAP_UP;
      activeVal_ff <= `CAP_CHV_RST;
      out_ff       <= 1'b0;
      start_ff     <= 1'b0;
      upOut_ff     <= 1'b1;
    end else begin
      cnt_ff       <= nxt_cnt;
      dir_ff       <= nxt_dir;
      activeVal_ff <= nxt_activeVal;
      out_ff       <= nxt_out;
      start_ff     <= nxt_start;
      upOut_ff     <= nxt_upOut;
    end
  end

  assign pwmOut       = out_ff;
  assign counterValue = cnt_ff;
  assign countingUp   = upOut_ff;
  assign periodStart  = start_ff;

  full_duty_a: assert property (@(posedge core_clk) disable iff (srst)
    (!activeVal_ff[15] && activeVal_ff >= moduloValue && $stable(moduloValue)
     && !start_ff) |-> out_ff)
    else $error("Full duty not held active");

  neg_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    activeVal_ff[15] |-> !out_ff)
    else $error("Negative value drove output active");

  compare_out_a: assert property (@(posedge core_clk) disable iff (srst)
    (!activeVal_ff[15] && activeVal_ff < moduloValue && $stable(moduloValue))
      |-> out_ff == (cnt_ff < activeVal_ff))
    else $error("Output disagrees with count compare");

  dir_down_a: assert property (@(posedge core_clk) disable iff (srst)
    (dir_ff == cap_pkg::CAP_DOWN && tickBus.tick && cnt_ff != 16'h0000)
      |=> cnt_ff == $past(cnt_ff) - 16'h0001)
    else $error("Down count step wrong");

  hold_mid_a: assert property (@(posedge core_clk) disable iff (srst)
    !start_ff |-> $stable(activeVal_ff))
    else $error("Duty changed inside a period");

  up_step_a: assert property (@(posedge core_clk) disable iff (srst)
    (dir_ff == cap_pkg::CAP_UP && tickBus.tick && cnt_ff < moduloValue)
      |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("Up count step wrong");

  bottom_turn_a: assert property (@(posedge core_clk) disable iff (srst)
    (dir_ff == cap_pkg::CAP_DOWN && tickBus.tick && cnt_ff == 16'h0000)
      |=> dir_ff == cap_pkg::CAP_UP)
    else $error("No turn to up counting at zero");

  top_turn_a: assert property (@(posedge core_clk) disable iff (srst)
    boundary |=> (dir_ff == cap_pkg::CAP_DOWN && start_ff))
    else $error("No turn to down counting at modulo");

  start_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    start_ff |=> !start_ff)
    else $error("Period start longer than one cycle");

  tick_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    !tickBus.tick |=> $stable(cnt_ff))
    else $error("Counter moved without a tick");

  zero_duty_a: assert property (@(posedge core_clk) disable iff (srst)
    (activeVal_ff == 16'h0000 && moduloValue != 16'h0000 && $stable(moduloValue))
      |-> !out_ff)
    else $error("Zero value drove output active");

  reset_state_a: assert property (@(posedge core_clk)
    srst |=> (cnt_ff == 16'h0000 && countingUp && !out_ff && !start_ff))
    else $error("Reset state wrong");
endmodule
`default_nettype wire

// *** verif/cap_pwm_channel_tb.sv ***
// Purpose: Self-checking bench for the center-aligned PWM channel
// Assumes: Duty latched at the period boundary, output active high
// Notes:   Modulo of 8 keeps a period short; duty changes mid period on purpose
`timescale 1ns/10ps
`default_nettype none
`include "cap_params.svh"
`define CAP_CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module cap_pwm_channel_tb;
  localparam logic [15:0] MOD = 16'h0008;
  logic        core_clk       = 1'b0;
  logic        srst           = 1'b1;
  logic [15:0] channelValue   = 16'h0004;
  logic [15:0] moduloValue    = MOD;
  logic [2:0]  prescaleSelect = 3'h0;
  logic        pwmOut;
  logic [15:0] counterValue;
  logic        countingUp;
  logic        periodStart;
  int          err_count      = 0;
  int          compares       = 0;
  int          cycles         = 0;
  // Changes land in the down half, except 3 to 0 which lands early in the up half
  logic [15:0] duty [10]      = '{16'h0004, 16'h0008, 16'h0007, 16'h8000, 16'hffff,
                                  16'h0000, 16'h0005, 16'h0003, 16'h0000, 16'h0004};
  int          chgAt [9]      = '{2, 2, 2, 2, 2, 2, 2, 8, 2};

  cap_pwm_channel dut (
    .core_clk       (core_clk),
    .srst           (srst),
    .channelValue   (channelValue),
    .moduloValue    (moduloValue),
    .prescaleSelect (prescaleSelect),
    .pwmOut         (pwmOut),
    .counterValue   (counterValue),
    .countingUp     (countingUp),
    .periodStart    (periodStart)
  );

  always #25 core_clk = ~core_clk;

  function automatic logic expv(input logic [15:0] d, input logic [15:0] c);
    if (d[15]) return 1'b0;
    if (d >= MOD) return 1'b1;
    return c < d;
  endfunction

  task automatic complete_run();
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Checks one whole period; a new value may be presented mid period
  task automatic period(input logic [15:0] d, input int chg, input logic [15:0] nv,
                        input int len, input bit en);
    int i;
    i = 0;
    while (periodStart !== 1'b1 && i < 5000) begin
      @(negedge core_clk);
      i++;
    end
    i = 0;
    do begin
      if (en) `CAP_CHK("pwmOut", expv(d, counterValue), pwmOut)
      if (en && i == 0) `CAP_CHK("top", {MOD - 16'h1, 1'b0}, {counterValue, countingUp})
      if (en && i == len - 1) `CAP_CHK("end", {MOD, 1'b1}, {counterValue, countingUp})
      @(posedge core_clk);
      if (i == chg) channelValue <= nv;
      @(negedge core_clk);
      i++;
    end while (periodStart !== 1'b1 && i < 5000);
    if (en) `CAP_CHK("periodLen", len, i)
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      period(duty[k], chgAt[k], duty[k + 1], 2 * MOD, 1'b1);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge core_clk);
      prescaleSelect <= c[2:0];
      period(16'h0004, -1, 16'h0004, 0, 1'b0);
      period(16'h0004, -1, 16'h0004, (c[2:0] == `CAP_PS_DIV2) ? 4 * MOD : 2 * MOD, 1'b1);
    end
    complete_run();
  end
endmodule
`default_nettype wire
